/* verilog/sovl_overlap.sv */
// Summary of operation
// RL1 - Overlap is green while any included phase is green.
// RL2 - Stay green across yellow or red clearance when another included phase is next.
// RL3 - With no included green, overlap is yellow if any included phase is yellow.
// RL4 - Overlap is red when no included phase is green or yellow.
// RL5 - Without trailing timing, overlap copies the terminating phase's yellow and red.
// RL6 - Last included phase entering yellow extends overlap green by trailing green time.
// RL7 - After trailing green, time trailing yellow then trailing red.
// RL8 - Trailing timing applies only when trailing green and yellow are both non-zero.
// RL9 - Sixteen independent overlaps A to P, each with own settings.
// RL10 - Minus variant: no green while a modifier phase is green or next.
// RL11 - Minus variant: red while any modifier phase is green or yellow.
// RL12 - With modifiers assigned, only included and modifier states matter; no trailing.
// RL13 - Any subset of phases 1 to 16 may be modifier phases.
// RL14 - Trailing times are 8-bit tenths of a second, counted on a 100 ms tick.
`timescale 1ns/1ps
`default_nettype none

module sovl_overlap
  import sovl_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire sovl_phase_t              phase_i,
  input  wire sovl_cfg_t [NUM_OVERLAPS-1:0] cfg_i,
  output var  sovl_color_t [NUM_OVERLAPS-1:0] color_o,
  output logic                          tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block
  typedef struct packed {
    logic [TICK_W-1:0]                tick_cnt;
    logic                             tick;
    sovl_ovl_t [NUM_OVERLAPS-1:0]     ovl;
    sovl_color_t [NUM_OVERLAPS-1:0]   color;
    logic [NUM_OVERLAPS-1:0]          active;
  } sovl_state_t;

  sovl_state_t state;
  sovl_state_t next_state;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);

  // Plain derivation from included phases, shared by both variants
  function automatic sovl_color_t sovl_follow(input sovl_cfg_t c, input sovl_phase_t p);
    logic g;
    logic bridge;
    logic y;
    g      = |(c.incl & p.green);                                   // RL1
    bridge = |(c.incl & (p.yellow | p.red)) && |(c.incl & p.next); // RL2
    y      = |(c.incl & p.yellow);
    if (g || bridge)
      sovl_follow = SOVL_GREEN;
    else if (y)
      sovl_follow = SOVL_YELLOW;                                    // RL3 RL5
    else
      sovl_follow = SOVL_RED;                                       // RL4 RL5
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: tick divider and one trailing machine per overlap
  always_comb
  begin
    sovl_color_t f;
    logic        timing;
    logic        trail_en;
    f          = SOVL_RED;
    timing     = 1'b0;
    trail_en   = 1'b0;
    next_state = state;
    // RL14 100 ms tick keeps the timers independent of phase timing jitter
    next_state.tick = (state.tick_cnt == TICK_LAST);
    if (state.tick_cnt == TICK_LAST)
      next_state.tick_cnt = '0;
    else
      next_state.tick_cnt = state.tick_cnt + 1'b1;

    for (int i = 0; i < NUM_OVERLAPS; i++)
    begin                                                           // RL9
      f      = sovl_follow(cfg_i[i], phase_i);
      timing = |(cfg_i[i].incl & (phase_i.green | phase_i.next));
      next_state.active[i] = (f == SOVL_GREEN);
      if (|cfg_i[i].modif)
      begin
        // RL12 modifiers override every other option, trailing state is dropped
        next_state.ovl[i].st  = SOVL_T_IDLE;
        next_state.ovl[i].cnt = '0;
        if (|(cfg_i[i].modif & (phase_i.green | phase_i.yellow)))
          next_state.color[i] = SOVL_RED;                           // RL11 RL13
        else if (f == SOVL_GREEN && |(cfg_i[i].modif & phase_i.next))
          next_state.color[i] = SOVL_RED;                           // RL10
        else
          next_state.color[i] = f;
      end
      else
      begin
        trail_en = (cfg_i[i].trail_green != '0) && (cfg_i[i].trail_yellow != '0); // RL8
        case (state.ovl[i].st)
          SOVL_T_IDLE:
          begin
            next_state.color[i] = f;
            // Last timing included phase leaves green
            if (trail_en && state.active[i] && f != SOVL_GREEN && !timing)
            begin
              next_state.ovl[i].st  = SOVL_T_GREEN;                 // RL6
              next_state.ovl[i].cnt = cfg_i[i].trail_green;
              next_state.color[i]   = SOVL_GREEN;
            end
          end
          SOVL_T_GREEN:
          begin
            next_state.color[i] = SOVL_GREEN;
            if (f == SOVL_GREEN)
              next_state.ovl[i].st = SOVL_T_IDLE;                   // Phase came back
            else if (state.tick && state.ovl[i].cnt <= 8'h01)
            begin
              next_state.ovl[i].st  = SOVL_T_YELLOW;                // RL7
              next_state.ovl[i].cnt = cfg_i[i].trail_yellow;
              next_state.color[i]   = SOVL_YELLOW;
            end
            else if (state.tick)
              next_state.ovl[i].cnt = state.ovl[i].cnt - 1'b1;      // RL14
          end
          SOVL_T_YELLOW:
          begin
            next_state.color[i] = SOVL_YELLOW;
            // An included phase back in green outranks the overlap's own clearance
            if (f == SOVL_GREEN)
            begin
              next_state.ovl[i].st = SOVL_T_IDLE;                   // RL1
              next_state.color[i]  = SOVL_GREEN;
            end
            else if (state.tick && state.ovl[i].cnt <= 8'h01)
            begin
              next_state.ovl[i].st  = SOVL_T_RED;                   // RL7
              next_state.ovl[i].cnt = cfg_i[i].trail_red;
              next_state.color[i]   = SOVL_RED;
            end
            else if (state.tick)
              next_state.ovl[i].cnt = state.ovl[i].cnt - 1'b1;
          end
          default:
          begin
            // Red clearance; a zero red time ends on the next tick
            next_state.color[i] = SOVL_RED;
            if (f == SOVL_GREEN)
            begin
              next_state.ovl[i].st = SOVL_T_IDLE;                   // RL1
              next_state.color[i]  = SOVL_GREEN;
            end
            else if (state.tick && state.ovl[i].cnt <= 8'h01)
              next_state.ovl[i].st = SOVL_T_IDLE;
            else if (state.tick)
              next_state.ovl[i].cnt = state.ovl[i].cnt - 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  // Outputs straight from flip-flops
  assign color_o = state.color;
  assign tick_o  = state.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on every overlap: the minus and trailing variants sit on different
  // overlaps, so checking one overlap alone would leave most checks idle
  for (genvar k = 0; k < NUM_OVERLAPS; k++)
  begin : g_chk
    sequence s_trail_start;
      state.ovl[k].st == SOVL_T_IDLE && $past(state.ovl[k].st) == SOVL_T_IDLE;
    endsequence

    a_green_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
      (cfg_i[k].modif == '0 && |(cfg_i[k].incl & phase_i.green))
        |=> color_o[k] == SOVL_GREEN)
      else $error("overlap not green with included green");

    a_modif_red: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL11
      (|(cfg_i[k].modif & (phase_i.green | phase_i.yellow))) |=> color_o[k] == SOVL_RED)
      else $error("overlap not red during modifier interval");

    a_modif_next: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL10
      (|(cfg_i[k].modif & phase_i.next)) |=> color_o[k] != SOVL_GREEN)
      else $error("overlap green while modifier next");

    a_no_trail_red: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
      (s_trail_start and ##0 (state.ovl[k].st == SOVL_T_IDLE &&
        !(|(cfg_i[k].incl & (phase_i.green | phase_i.yellow | phase_i.red)))))
        |=> (color_o[k] == SOVL_RED || state.ovl[k].st == SOVL_T_GREEN))
      else $error("overlap not red with no included interval");

    a_trail_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL8
      (cfg_i[k].trail_green == '0 || cfg_i[k].trail_yellow == '0) &&
        state.ovl[k].st == SOVL_T_IDLE |=> state.ovl[k].st == SOVL_T_IDLE)
      else $error("trailing timing started while disabled");

    a_trail_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL7
      $changed(state.ovl[k].st) && state.ovl[k].st == SOVL_T_YELLOW
        |-> $past(state.ovl[k].st) == SOVL_T_GREEN && color_o[k] == SOVL_YELLOW)
      else $error("trailing yellow not after trailing green");

    a_modif_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL12
      cfg_i[k].modif != '0 |=> state.ovl[k].st == SOVL_T_IDLE)
      else $error("trailing timing with modifiers assigned");
  end

  // The tick is shared by all overlaps

  a_tick_period: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL14
    tick_o |=> !tick_o)
    else $error("timing tick longer than one cycle");

endmodule

`default_nettype wire

/* verilog/sovl_pkg.sv */
package sovl_pkg;

  // Phase and overlap counts
  localparam int unsigned NUM_PHASES   = 16;
  localparam int unsigned NUM_OVERLAPS = 16;
  localparam int unsigned TIME_W       = 8;

  // Timing tick: 100 ms at a 40 MHz clock
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W       = 22;

  // Overlap output colour encoding
  typedef enum logic [1:0] {
    SOVL_RED    = 2'h0,
    SOVL_GREEN  = 2'h1,
    SOVL_YELLOW = 2'h3
  } sovl_color_t;

  // Trailing sequence states, Gray along the usual path
  typedef enum logic [1:0] {
    SOVL_T_IDLE   = 2'h0,
    SOVL_T_GREEN  = 2'h1,
    SOVL_T_YELLOW = 2'h3,
    SOVL_T_RED    = 2'h2
  } sovl_trail_t;

  // Per-phase interval states from the sequencer
  typedef struct packed {
    logic [NUM_PHASES-1:0] green;
    logic [NUM_PHASES-1:0] yellow;
    logic [NUM_PHASES-1:0] red;
    logic [NUM_PHASES-1:0] next;
  } sovl_phase_t;

  // Configuration of one overlap
  typedef struct packed {
    logic [NUM_PHASES-1:0] incl;
    logic [NUM_PHASES-1:0] modif;
    logic [TIME_W-1:0]     trail_green;
    logic [TIME_W-1:0]     trail_yellow;
    logic [TIME_W-1:0]     trail_red;
  } sovl_cfg_t;

  // Per-overlap trailing timer state
  typedef struct packed {
    sovl_trail_t       st;
    logic [TIME_W-1:0] cnt;
  } sovl_ovl_t;

endpackage

/* sim/sovl_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sovl_seq_model
  import sovl_pkg::*;
(
  input  wire sovl_phase_t set_i,
  output var  sovl_phase_t phase_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // A phase times one interval at a time; a phase in green is never also next
  always_comb
  begin
    phase_o.green  = set_i.green;
    phase_o.yellow = set_i.yellow & ~set_i.green;
    phase_o.red    = set_i.red & ~set_i.yellow & ~set_i.green;
    phase_o.next   = set_i.next & ~set_i.green;
  end
endmodule

`default_nettype wire

/* sim/signal_overlap_state_logic_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module signal_overlap_state_logic_bench
  import sovl_pkg::*;
;
  localparam int TL = 10;
  logic                           clk_i = 1'b0;
  logic                           rst_n_i;
  logic                           tick;
  sovl_phase_t                    set;
  sovl_phase_t                    ph;
  sovl_cfg_t   [NUM_OVERLAPS-1:0] cfg;
  sovl_color_t [NUM_OVERLAPS-1:0] col;
  int                             error_cnt = 0;
  int                             n_compared = 0;
  int                             cyc = 0;
  int                             n;

  sovl_seq_model i_seq (.set_i(set), .phase_o(ph));
  sovl_overlap #(.TICK_LEN(TL)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .phase_i(ph),
    .cfg_i(cfg), .color_o(col), .tick_o(tick));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling well above the fewer than two hundred cycles the tests need
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Drive phase states after a falling edge; colour is settled one falling edge later
  task automatic drive(input logic [15:0] g, y, r, nx);
    set = '{g, y, r, nx};
    @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A = 1+2, B = 1 minus 6, C = 1 with trailing, D = 1 with zero trailing yellow, E = 1 minus 16, F = 3
  initial
  begin
    rst_n_i = 1'b0;
    set = '0;
    cfg = '0;
    cfg[0].incl = 16'h0003;
    cfg[1].incl = 16'h0001;
    cfg[1].modif = 16'h0020;
    cfg[2] = '{16'h0001, 16'h0000, 8'h03, 8'h02, 8'h02};
    cfg[3] = '{16'h0001, 16'h0000, 8'h03, 8'h00, 8'h02};
    cfg[4] = '{16'h0001, 16'h8000, 8'h03, 8'h02, 8'h02};
    cfg[5].incl = 16'h0004;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(col, 32'h0);
    drive(16'h0004, 16'h0, 16'h0, 16'h0);
    chk(col, 32'h0000_0400);
    drive(16'h0001, 16'h0, 16'h0, 16'h0);
    chk(col[4:0], 10'h155);
    drive(16'h0001, 16'h0, 16'h0, 16'h0020);
    chk(col[1], SOVL_RED);
    drive(16'h0021, 16'h0, 16'h0, 16'h0);
    chk(col[1], SOVL_RED);
    // Phase 1 ends with 2 next: A bridges, C starts trailing, D and E copy yellow
    drive(16'h0, 16'h0001, 16'h0, 16'h0002);
    chk(col[0], SOVL_GREEN);
    chk(col[1], SOVL_YELLOW);
    chk(col[3], SOVL_YELLOW);
    chk(col[4], SOVL_YELLOW);
    drive(16'h0, 16'h0, 16'h0001, 16'h0);
    chk(col[3], SOVL_RED);
    // Trailing green is three ticks, less up to one tick of phase
    n = 1;
    while (col[2] === SOVL_GREEN && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= 20 && n <= 32, 1'b1);
    chk(col[2], SOVL_YELLOW);
    n = 0;
    while (col[2] === SOVL_YELLOW && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n, 2 * TL);
    chk(col[2], SOVL_RED);
    repeat (4 * TL) @(negedge clk_i);
    drive(16'h0, 16'h0, 16'h0, 16'h0);
    chk(col, 32'h0);
    while (tick !== 1'b1)
      @(negedge clk_i);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (tick !== 1'b1);
    chk(n, TL);
    close_out();
  end
endmodule

`default_nettype wire
